// *** design/rmpc_defines.svh ***
`ifndef RMPC_DEFINES_SVH
`define RMPC_DEFINES_SVH

// link table size
`define RMPC_MAX_LINKS 5'h14
`define RMPC_LINK_IDX_W 5

// register byte offsets
`define RMPC_OFF_LIMIT 8'h00
`define RMPC_OFF_CMD 8'h04
`define RMPC_OFF_STATUS 8'h08
`define RMPC_OFF_LINKS 8'h0c
`define RMPC_OFF_ROLES 8'h10

// limit register fields
`define RMPC_LIM_PERIPH_LSB 0
`define RMPC_LIM_CENTRAL_LSB 8
`define RMPC_LIM_PERIPH_RST 5'h01
`define RMPC_LIM_CENTRAL_RST 5'h01

// command register bits
`define RMPC_CMD_SCAN 0
`define RMPC_CMD_ADV 1
`define RMPC_CMD_ENTER_CFG 2
`define RMPC_CMD_EXIT_CFG 3
`define RMPC_CMD_STOP 4

// status register bits
`define RMPC_ST_SLEEP 0
`define RMPC_ST_CONFIG 1
`define RMPC_ST_UART_DEF 2
`define RMPC_ST_SCAN 3
`define RMPC_ST_ADV 4
`define RMPC_ST_DROP 5
`define RMPC_ST_CENTRAL_LSB 8
`define RMPC_ST_PERIPH_LSB 16

// synchroniser idle levels of the pins
`define RMPC_PIN_HIGH_RST 1'b1
`define RMPC_PIN_LOW_RST 1'b0

`endif

// *** design/rmpc_pkg.sv ***
package rmpc_pkg;

	typedef enum logic [0:0] {
		RMPC_RR_IDLE = 1'b0,
		RMPC_RR_SEND = 1'b1
	} rmpc_rr_state_type;

	typedef logic [4:0] rmpc_idx_type;

endpackage

// *** design/rmpc_sync.sv ***
module rmpc_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic level
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// level follows only once two later stages agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level <= RESET_VAL;
		end else if (s2_reg == s3_reg) begin
			level <= s3_reg;
		end
	end

endmodule

// *** design/rmpc_top.sv ***
// Implementation choices: the plain strobed port and the placing of the registers.
`include "rmpc_defines.svh"
module rmpc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reset_in,
	input wire logic sleep_req_in,
	input wire logic config_sel_in,
	input wire logic link_drop_in,
	output logic sleep_status_out,
	output logic mode_status_out,
	output logic advertising_status_out,
	output logic scanning_out,
	output logic uart_default_out,
	output logic link_drop_req_out,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic conn_open,
	input wire logic conn_open_central,
	input wire logic [4:0] conn_open_idx,
	input wire logic conn_close,
	input wire logic [4:0] conn_close_idx,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic link_tx_valid,
	output logic [4:0] link_tx_idx,
	output logic [7:0] link_tx_data,
	input wire logic link_tx_ready
);

	localparam int NL = 20;

	logic reset_sync;
	logic sleep_sync;
	logic cfg_sync;
	logic drop_sync;
	logic rst_int_n;
	logic cfg_prev_reg;
	logic config_reg;
	logic pin_cfg_reg;
	logic scan_cmd_reg;
	logic adv_cmd_reg;
	logic [4:0] periph_max_reg;
	logic [4:0] central_max_reg;
	logic [NL-1:0] active_reg;
	logic [NL-1:0] active_next;
	logic [NL-1:0] central_reg;
	logic [NL-1:0] central_next;
	logic [NL-1:0] pend_reg;
	logic [4:0] central_cnt;
	logic [4:0] periph_cnt;
	logic [5:0] total_cnt;
	logic sleeping;
	logic central_full;
	logic periph_full;
	logic scan_en;
	logic adv_en;
	logic wr_limit;
	logic wr_cmd;
	logic [4:0] new_periph;
	logic [4:0] new_central;
	logic [5:0] new_sum;
	logic [7:0] tx_byte_reg;
	rmpc_pkg::rmpc_idx_type idx_reg;
	rmpc_pkg::rmpc_rr_state_type rr_state_reg;

	function automatic logic [4:0] rmpc_popcount(input logic [NL-1:0] v);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < NL; i++) begin
			c = c + {4'h0, v[i]};
		end
		return c;
	endfunction

	// reset pin idles low, control pins idle high
	rmpc_sync #(.RESET_VAL(`RMPC_PIN_LOW_RST)) u_sync_reset (
		.clk(clk),
		.rst_n(rst_n),
		.pin(reset_in),
		.level(reset_sync)
	);

	rmpc_sync #(.RESET_VAL(`RMPC_PIN_HIGH_RST)) u_sync_sleep (
		.clk(clk),
		.rst_n(rst_n),
		.pin(sleep_req_in),
		.level(sleep_sync)
	);

	rmpc_sync #(.RESET_VAL(`RMPC_PIN_HIGH_RST)) u_sync_cfg (
		.clk(clk),
		.rst_n(rst_n),
		.pin(config_sel_in),
		.level(cfg_sync)
	);

	rmpc_sync #(.RESET_VAL(`RMPC_PIN_HIGH_RST)) u_sync_drop (
		.clk(clk),
		.rst_n(rst_n),
		.pin(link_drop_in),
		.level(drop_sync)
	);

	assign rst_int_n = rst_n && !reset_sync;

	assign wr_limit = reg_wr && (reg_addr == `RMPC_OFF_LIMIT);
	assign wr_cmd = reg_wr && (reg_addr == `RMPC_OFF_CMD);

	// configuration mode: pin falling edge enters, pin rising edge or exit command leaves
	always_ff @(posedge clk) begin
		if (!rst_int_n) begin
			cfg_prev_reg <= `RMPC_PIN_HIGH_RST;
			config_reg <= 1'b0;
			pin_cfg_reg <= 1'b0;
		end else begin
			cfg_prev_reg <= cfg_sync;
			if (cfg_prev_reg && !cfg_sync) begin
				config_reg <= 1'b1;
				pin_cfg_reg <= 1'b1;
			end else if (!cfg_prev_reg && cfg_sync && config_reg) begin
				config_reg <= 1'b0;
				pin_cfg_reg <= 1'b0;
			end else if (wr_cmd && reg_wdata[`RMPC_CMD_EXIT_CFG]) begin
				config_reg <= 1'b0;
				pin_cfg_reg <= 1'b0;
			end else if (wr_cmd && reg_wdata[`RMPC_CMD_ENTER_CFG] && !config_reg) begin
				config_reg <= 1'b1;
				pin_cfg_reg <= 1'b0;
			end
		end
	end

	assign sleeping = sleep_sync && !config_reg;

	// limits are clamped so the two roles together never pass the link table size
	assign new_periph = (reg_wdata[`RMPC_LIM_PERIPH_LSB +: 5] > `RMPC_MAX_LINKS) ?
		`RMPC_MAX_LINKS : reg_wdata[`RMPC_LIM_PERIPH_LSB +: 5];
	assign new_sum = {1'b0, new_periph} + {1'b0, reg_wdata[`RMPC_LIM_CENTRAL_LSB +: 5]};
	assign new_central = (new_sum > {1'b0, `RMPC_MAX_LINKS}) ?
		(`RMPC_MAX_LINKS - new_periph) : reg_wdata[`RMPC_LIM_CENTRAL_LSB +: 5];

	always_ff @(posedge clk) begin
		if (!rst_int_n) begin
			periph_max_reg <= `RMPC_LIM_PERIPH_RST;
			central_max_reg <= `RMPC_LIM_CENTRAL_RST;
		end else if (wr_limit) begin
			periph_max_reg <= new_periph;
			central_max_reg <= new_central;
		end
	end

	assign central_cnt = rmpc_popcount(active_reg & central_reg);
	assign periph_cnt = rmpc_popcount(active_reg & ~central_reg);
	assign total_cnt = {1'b0, central_cnt} + {1'b0, periph_cnt};
	assign central_full = central_cnt >= central_max_reg;
	assign periph_full = periph_cnt >= periph_max_reg;

	// link table; a drop request clears it, sleep leaves it alone
	always_comb begin
		active_next = active_reg;
		central_next = central_reg;
		if (conn_close && (conn_close_idx < `RMPC_MAX_LINKS)) begin
			active_next[conn_close_idx] = 1'b0;
		end
		if (conn_open && (conn_open_idx < `RMPC_MAX_LINKS) && !active_reg[conn_open_idx]
				&& (total_cnt < {1'b0, `RMPC_MAX_LINKS})
				&& (conn_open_central ? !central_full : !periph_full)) begin
			active_next[conn_open_idx] = 1'b1;
			central_next[conn_open_idx] = conn_open_central;
		end
		if (!drop_sync) begin
			active_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_int_n) begin
			active_reg <= '0;
			central_reg <= '0;
		end else begin
			active_reg <= active_next;
			central_reg <= central_next;
		end
	end

	// manual scan and advertise commands, honoured only in configuration mode
	always_ff @(posedge clk) begin
		if (!rst_int_n) begin
			scan_cmd_reg <= 1'b0;
		end else if (!config_reg || central_full || (wr_cmd && reg_wdata[`RMPC_CMD_STOP])) begin
			scan_cmd_reg <= 1'b0;
		end else if (wr_cmd && reg_wdata[`RMPC_CMD_SCAN] && (central_max_reg != 5'h00)) begin
			scan_cmd_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_int_n) begin
			adv_cmd_reg <= 1'b0;
		end else if (!config_reg || periph_full || (wr_cmd && reg_wdata[`RMPC_CMD_STOP])) begin
			adv_cmd_reg <= 1'b0;
		end else if (wr_cmd && reg_wdata[`RMPC_CMD_ADV] && (periph_max_reg != 5'h00)) begin
			adv_cmd_reg <= 1'b1;
		end
	end

	assign scan_en = (central_max_reg != 5'h00) && !central_full && !sleeping
		&& (config_reg ? scan_cmd_reg : 1'b1);
	assign adv_en = (periph_max_reg != 5'h00) && !periph_full && !sleeping
		&& (config_reg ? adv_cmd_reg : 1'b1);

	always_ff @(posedge clk) begin
		if (!rst_int_n) begin
			sleep_status_out <= 1'b1;
			mode_status_out <= 1'b1;
			advertising_status_out <= 1'b0;
			scanning_out <= 1'b0;
			uart_default_out <= 1'b0;
			link_drop_req_out <= 1'b0;
		end else begin
			sleep_status_out <= !sleeping;
			mode_status_out <= !config_reg;
			advertising_status_out <= adv_en;
			scanning_out <= scan_en;
			uart_default_out <= pin_cfg_reg;
			link_drop_req_out <= !drop_sync;
		end
	end

	// round robin: each byte goes to every open link once, lowest index first
	assign tx_ready = (rr_state_reg == rmpc_pkg::RMPC_RR_IDLE);
	assign link_tx_valid = (rr_state_reg == rmpc_pkg::RMPC_RR_SEND)
		&& pend_reg[idx_reg] && active_reg[idx_reg];

	always_ff @(posedge clk) begin
		if (!rst_int_n) begin
			rr_state_reg <= rmpc_pkg::RMPC_RR_IDLE;
			pend_reg <= '0;
			idx_reg <= 5'h00;
			tx_byte_reg <= 8'h00;
		end else begin
			case (rr_state_reg)
				rmpc_pkg::RMPC_RR_IDLE: begin
					idx_reg <= 5'h00;
					if (tx_valid && (active_reg != '0)) begin
						tx_byte_reg <= tx_data;
						pend_reg <= active_reg;
						rr_state_reg <= rmpc_pkg::RMPC_RR_SEND;
					end
				end
				rmpc_pkg::RMPC_RR_SEND: begin
					if ((pend_reg & active_reg) == '0) begin
						pend_reg <= '0;
						rr_state_reg <= rmpc_pkg::RMPC_RR_IDLE;
					end else if (!pend_reg[idx_reg] || !active_reg[idx_reg] || link_tx_ready) begin
						pend_reg[idx_reg] <= 1'b0;
						idx_reg <= (idx_reg == (`RMPC_MAX_LINKS - 5'h01)) ? 5'h00 : (idx_reg + 5'h01);
					end
				end
				default: begin
					rr_state_reg <= rmpc_pkg::RMPC_RR_IDLE;
				end
			endcase
		end
	end

	assign link_tx_idx = idx_reg;
	assign link_tx_data = tx_byte_reg;

	// read port: data one cycle after the strobe, zero for unmapped offsets
	always_ff @(posedge clk) begin
		if (!rst_int_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			if (reg_addr == `RMPC_OFF_LIMIT) begin
				reg_rdata <= {19'h00000, central_max_reg, 3'h0, periph_max_reg};
			end else if (reg_addr == `RMPC_OFF_STATUS) begin
				reg_rdata <= {11'h000, periph_cnt, 3'h0, central_cnt, 2'h0, !drop_sync,
					adv_en, scan_en, pin_cfg_reg, config_reg, sleeping};
			end else if (reg_addr == `RMPC_OFF_LINKS) begin
				reg_rdata <= {12'h000, active_reg};
			end else if (reg_addr == `RMPC_OFF_ROLES) begin
				reg_rdata <= {12'h000, central_reg & active_reg};
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

// *** test/rmpc_link_model.sv ***
module rmpc_link_model #(
	parameter int DELAY = 2
) (
	input wire logic clk,
	input wire logic link_tx_valid,
	input wire logic [4:0] link_tx_idx,
	input wire logic [7:0] link_tx_data,
	output logic link_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_cnt = 0;
	logic [12:0] got_q[$];
	initial link_tx_ready = 1'b0;
	// stalls every byte a few cycles before taking it
	always @(posedge clk) begin
		if (link_tx_valid && link_tx_ready)
			got_q.push_back({link_tx_idx, link_tx_data});
		link_tx_ready <= link_tx_valid && !link_tx_ready && wait_cnt >= DELAY;
		wait_cnt <= (link_tx_valid && !link_tx_ready) ? wait_cnt + 1 : 0;
	end
endmodule

// *** test/rmpc_top_props.sv ***
module rmpc_top_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sleep_req_in,
	input wire logic config_sel_in,
	input wire logic link_drop_in,
	input wire logic sleep_status_out,
	input wire logic mode_status_out,
	input wire logic advertising_status_out,
	input wire logic scanning_out,
	input wire logic uart_default_out,
	input wire logic link_drop_req_out,
	input wire logic link_tx_valid,
	input wire logic [4:0] link_tx_idx,
	input wire logic [7:0] link_tx_data,
	input wire logic link_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence cfg_held;
		(!config_sel_in) [*8];
	endsequence
	sequence byte_stalled;
		link_tx_valid && !link_tx_ready;
	endsequence
	mode_low_a: assert property (cfg_held |-> !mode_status_out)
		else $error("mode status not low");
	cfg_awake_a: assert property (cfg_held |=> sleep_status_out)
		else $error("asleep in configuration");
	uart_force_a: assert property (cfg_held |=> uart_default_out)
		else $error("serial default not forced");
	sleep_low_a: assert property ((sleep_req_in && config_sel_in && mode_status_out) [*8] |-> !sleep_status_out)
		else $error("sleep status not low");
	wake_high_a: assert property ((!sleep_req_in) [*8] |-> sleep_status_out)
		else $error("sleep status not high");
	sleep_halt_a: assert property ((!sleep_status_out) [*2] |-> !scanning_out && !advertising_status_out)
		else $error("scan or advertise while asleep");
	drop_req_a: assert property ((!link_drop_in) [*8] |-> link_drop_req_out)
		else $error("link drop not requested");
	rr_hold_a: assert property (byte_stalled |=> link_tx_valid && $stable(link_tx_idx) && $stable(link_tx_data))
		else $error("link byte not held");
	rr_order_a: assert property (link_tx_valid && link_tx_ready |=> !link_tx_valid || link_tx_idx > $past(link_tx_idx))
		else $error("link order broken");
endmodule

bind rmpc_top rmpc_top_props rmpc_top_props_inst (
	.clk(clk),
	.rst_n(rst_n),
	.sleep_req_in(sleep_req_in),
	.config_sel_in(config_sel_in),
	.link_drop_in(link_drop_in),
	.sleep_status_out(sleep_status_out),
	.mode_status_out(mode_status_out),
	.advertising_status_out(advertising_status_out),
	.scanning_out(scanning_out),
	.uart_default_out(uart_default_out),
	.link_drop_req_out(link_drop_req_out),
	.link_tx_valid(link_tx_valid),
	.link_tx_idx(link_tx_idx),
	.link_tx_data(link_tx_data),
	.link_tx_ready(link_tx_ready)
);

// *** test/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, reset_in = 0, sleep_req_in = 0, config_sel_in = 1, link_drop_in = 1;
	logic [7:0] reg_addr = 0, tx_data = 0;
	logic [31:0] reg_wdata = 0, reg_rdata;
	logic reg_wr = 0, reg_rd = 0, conn_open = 0, conn_open_central = 0, conn_close = 0, tx_valid = 0;
	logic [4:0] conn_open_idx = 0, conn_close_idx = 0, link_tx_idx;
	logic sleep_status_out, mode_status_out, advertising_status_out, scanning_out, uart_default_out;
	logic link_drop_req_out, tx_ready, link_tx_valid, link_tx_ready;
	logic [7:0] link_tx_data;
	int err_count = 0, n_checks = 0, cyc = 0;
	localparam int P_SLEEP = 0;
	localparam int P_CFG = 1;
	localparam int P_DROP = 2;
	localparam int P_RST = 3;
	rmpc_top rmpc_top_inst (
		.clk(clk),
		.rst_n(rst_n),
		.reset_in(reset_in),
		.sleep_req_in(sleep_req_in),
		.config_sel_in(config_sel_in),
		.link_drop_in(link_drop_in),
		.sleep_status_out(sleep_status_out),
		.mode_status_out(mode_status_out),
		.advertising_status_out(advertising_status_out),
		.scanning_out(scanning_out),
		.uart_default_out(uart_default_out),
		.link_drop_req_out(link_drop_req_out),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.conn_open(conn_open),
		.conn_open_central(conn_open_central),
		.conn_open_idx(conn_open_idx),
		.conn_close(conn_close),
		.conn_close_idx(conn_close_idx),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_ready(tx_ready),
		.link_tx_valid(link_tx_valid),
		.link_tx_idx(link_tx_idx),
		.link_tx_data(link_tx_data),
		.link_tx_ready(link_tx_ready)
	);
	rmpc_link_model rmpc_link_model_inst (
		.clk(clk),
		.link_tx_valid(link_tx_valid),
		.link_tx_idx(link_tx_idx),
		.link_tx_data(link_tx_data),
		.link_tx_ready(link_tx_ready)
	);
	always #12.5 clk = ~clk;
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", exp, reg_rdata);
	endtask
	task automatic link(input logic op, input logic [4:0] i);
		@(posedge clk);
		conn_open <= op;
		conn_close <= !op;
		conn_open_idx <= i;
		conn_close_idx <= i;
		conn_open_central <= 1'b1;
		@(posedge clk);
		conn_open <= 1'b0;
		conn_close <= 1'b0;
	endtask
	task automatic pin(input int sel, input logic v);
		@(posedge clk);
		if (sel == P_SLEEP)
			sleep_req_in <= v;
		else if (sel == P_CFG)
			config_sel_in <= v;
		else if (sel == P_DROP)
			link_drop_in <= v;
		else
			reset_in <= v;
		tick(8);
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		tx_data <= b;
		tx_valid <= 1'b1;
		for (int k = 0; k < 60; k++) begin
			@(negedge clk);
			if (tx_ready === 1'b1)
				break;
		end
		@(posedge clk);
		tx_valid <= 1'b0;
	endtask
	task automatic t_regs;
		rd(8'h00, 32'h101);
		rd(8'h14, 32'h0);
		wr(8'h00, 32'hf0f);
		rd(8'h00, 32'h50f);
		wr(8'h00, 32'h200);
		rd(8'h00, 32'h200);
		$display("regs done");
	endtask
	task automatic t_scan;
		tick(8);
		check("scanning_out", 1'b1, scanning_out);
		check("advertising_status_out", 1'b0, advertising_status_out);
		link(1'b1, 5'h00);
		link(1'b1, 5'h02);
		tick(3);
		check("scanning_out", 1'b0, scanning_out);
		rd(8'h08, 32'h200);
		rd(8'h10, 32'h5);
		$display("scan done");
	endtask
	task automatic t_rr;
		send(8'h5a);
		tick(1);
		check("tx_ready", 1'b0, tx_ready);
		send(8'ha5);
		for (int k = 0; k < 80 && rmpc_link_model_inst.got_q.size() < 4; k++)
			tick(1);
		tick(2);
		check("tx_ready", 1'b1, tx_ready);
		for (int k = 0; k < 4; k++)
			check("link byte", {k[0] ? 5'h02 : 5'h00, k[1] ? 8'ha5 : 8'h5a}, rmpc_link_model_inst.got_q[k]);
		$display("round robin done");
	endtask
	task automatic t_sleep;
		link(1'b0, 5'h02);
		tick(3);
		check("scanning_out", 1'b1, scanning_out);
		pin(P_SLEEP, 1'b1);
		check("sleep_status_out", 1'b0, sleep_status_out);
		check("scanning_out", 1'b0, scanning_out);
		rd(8'h0c, 32'h1);
		pin(P_SLEEP, 1'b0);
		check("sleep_status_out", 1'b1, sleep_status_out);
		$display("sleep done");
	endtask
	task automatic t_cfg;
		pin(P_CFG, 1'b0);
		check("mode_status_out", 1'b0, mode_status_out);
		check("uart_default_out", 1'b1, uart_default_out);
		check("scanning_out", 1'b0, scanning_out);
		pin(P_SLEEP, 1'b1);
		check("sleep_status_out", 1'b1, sleep_status_out);
		wr(8'h04, 32'h1);
		tick(3);
		check("scanning_out", 1'b1, scanning_out);
		pin(P_SLEEP, 1'b0);
		pin(P_CFG, 1'b1);
		check("mode_status_out", 1'b1, mode_status_out);
		check("scanning_out", 1'b1, scanning_out);
		wr(8'h00, 32'h0);
		tick(3);
		check("scanning_out", 1'b0, scanning_out);
		$display("config done");
	endtask
	task automatic t_drop_reset;
		pin(P_DROP, 1'b0);
		check("link_drop_req_out", 1'b1, link_drop_req_out);
		rd(8'h0c, 32'h0);
		pin(P_DROP, 1'b1);
		check("link_drop_req_out", 1'b0, link_drop_req_out);
		wr(8'h00, 32'h303);
		tick(3);
		check("advertising_status_out", 1'b1, advertising_status_out);
		pin(P_RST, 1'b1);
		check("mode_status_out", 1'b1, mode_status_out);
		check("advertising_status_out", 1'b0, advertising_status_out);
		check("scanning_out", 1'b0, scanning_out);
		pin(P_RST, 1'b0);
		rd(8'h00, 32'h101);
		$display("drop and reset done");
	endtask
	task automatic t_cmd;
		wr(8'h04, 32'h4);
		tick(3);
		check("mode_status_out", 1'b0, mode_status_out);
		check("uart_default_out", 1'b0, uart_default_out);
		check("scanning_out", 1'b0, scanning_out);
		wr(8'h04, 32'h3);
		tick(3);
		check("scanning_out", 1'b1, scanning_out);
		check("advertising_status_out", 1'b1, advertising_status_out);
		rd(8'h08, 32'h1a);
		wr(8'h04, 32'h10);
		tick(3);
		check("scanning_out", 1'b0, scanning_out);
		check("advertising_status_out", 1'b0, advertising_status_out);
		wr(8'h04, 32'h8);
		tick(3);
		check("mode_status_out", 1'b1, mode_status_out);
		check("scanning_out", 1'b1, scanning_out);
		$display("command done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_scan();
		t_rr();
		t_sleep();
		t_cfg();
		t_drop_reset();
		t_cmd();
		print_verdict();
	end
endmodule
